// ---- verilog/pe_defs.svh ----
`ifndef PE_DEFS_SVH
`define PE_DEFS_SVH

// Register indices; byte address is four times the index
`define PE_IDX_W        10
`define PE_ADDR_W       12
`define PE_IDX_DATA     10'h009
`define PE_IDX_DIR      10'h089
`define PE_IDX_ANSEL    10'h0A0
`define PE_IDX_PSPBUF   10'h0A1

// Direction and slave-port control field positions
`define PE_BIT_IN_FULL   7
`define PE_BIT_OUT_FULL  6
`define PE_BIT_IN_OVF    5
`define PE_BIT_SLAVE_SEL 4

// Reset values
`define PE_DIR_RST      3'h7
`define PE_ANSEL_RST    3'h7
`define PE_LATCH_RST    3'h0
`define PE_WORD_RST     8'h00

// AXI responses
`define PE_RESP_OKAY    2'h0
`define PE_RESP_SLVERR  2'h2

`endif

// ---- verilog/pe_pkg.sv ----
package pe_pkg;
    typedef logic [2:0] pe_pins_t;
    typedef logic [7:0] pe_byte_t;
endpackage

// ---- verilog/pe_reg_if.sv ----
`timescale 1ns/100ps
`include "pe_defs.svh"

interface pe_reg_if;
    import pe_pkg::*;
    logic                  wrEn;
    logic [`PE_IDX_W-1:0]  wrIdx;
    pe_byte_t              wrData;
    logic                  wrStrb;
    logic                  wrErr;
    logic                  rdEn;
    logic [`PE_IDX_W-1:0]  rdIdx;
    pe_byte_t              rdData;
    logic                  rdErr;

    modport bus  (output wrEn, wrIdx, wrData, wrStrb, rdEn, rdIdx,
                  input  wrErr, rdData, rdErr);
    modport regs (input  wrEn, wrIdx, wrData, wrStrb, rdEn, rdIdx,
                  output wrErr, rdData, rdErr);
endinterface

// ---- verilog/pe_axil_slave.sv ----
`timescale 1ns/100ps
`include "pe_defs.svh"

module pe_axil_slave
    import pe_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // AXI4-Lite write
    input  wire logic                  s_axi_awvalid,
    output      logic                  s_axi_awready,
    input  wire logic [`PE_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_wvalid,
    output      logic                  s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    output      logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output      logic [1:0]            s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                  s_axi_arvalid,
    output      logic                  s_axi_arready,
    input  wire logic [`PE_ADDR_W-1:0] s_axi_araddr,
    output      logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output      logic [31:0]           s_axi_rdata,
    output      logic [1:0]            s_axi_rresp,
    // Register side
    pe_reg_if.bus                      rb
);
    logic                  awHeld_ff;
    logic [`PE_IDX_W-1:0]  awIdx_ff;
    logic                  wHeld_ff;
    pe_byte_t              wData_ff;
    logic                  wStrb_ff;
    logic                  bvalid_ff;
    logic [1:0]            bresp_ff;
    logic                  rvalid_ff;
    pe_byte_t              rdata_ff;
    logic [1:0]            rresp_ff;

    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake  = s_axi_wvalid && s_axi_wready;
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire doWr   = awHeld_ff && wHeld_ff && !bvalid_ff;

    assign s_axi_awready = !awHeld_ff && !bvalid_ff;
    assign s_axi_wready  = !wHeld_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = {24'h000000, rdata_ff};
    assign s_axi_rresp   = rresp_ff;

    // Side effects of a read fire once, on the address handshake
    assign rb.wrEn   = doWr;
    assign rb.wrIdx  = awIdx_ff;
    assign rb.wrData = wData_ff;
    assign rb.wrStrb = wStrb_ff;
    assign rb.rdEn   = arTake;
    assign rb.rdIdx  = s_axi_araddr[`PE_ADDR_W-1:2];

    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            bvalid_ff <= 1'b0;
        end else begin
            awHeld_ff <= doWr ? 1'b0 : (awHeld_ff | awTake);
            wHeld_ff  <= doWr ? 1'b0 : (wHeld_ff | wTake);
            bvalid_ff <= doWr | (bvalid_ff & ~s_axi_bready);
        end
    end

    always_ff @(posedge clk) begin
        if (awTake) awIdx_ff <= s_axi_awaddr[`PE_ADDR_W-1:2];
        if (wTake) begin
            wData_ff <= s_axi_wdata[7:0];
            wStrb_ff <= s_axi_wstrb[0];
        end
        if (doWr) bresp_ff <= rb.wrErr ? `PE_RESP_SLVERR : `PE_RESP_OKAY;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= `PE_WORD_RST;
            rresp_ff  <= `PE_RESP_OKAY;
        end else if (arTake) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rb.rdData;
            rresp_ff  <= rb.rdErr ? `PE_RESP_SLVERR : `PE_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule

// ---- verilog/pe_port.sv ----
`timescale 1ns/100ps
`include "pe_defs.svh"

// What this block does
// - Three pins, each independently input or output
// - Bit 4 selects slave strobes, resets 0
// - Analog-selected pins read back as zero
// - Direction bits govern even analog pins, except in slave mode
// - All pins analog after reset
// - Bit 7 input full, read-only, resets 0
// - Bit 6 output full until word read
// - Bit 5 overflow, set by hardware or by writing 1
// - Bits 2:0 direction, 1 input, reset 1
module pe_port
    import pe_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // AXI4-Lite write
    input  wire logic                  s_axi_awvalid,
    output      logic                  s_axi_awready,
    input  wire logic [`PE_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_wvalid,
    output      logic                  s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    output      logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output      logic [1:0]            s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                  s_axi_arvalid,
    output      logic                  s_axi_arready,
    input  wire logic [`PE_ADDR_W-1:0] s_axi_araddr,
    output      logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output      logic [31:0]           s_axi_rdata,
    output      logic [1:0]            s_axi_rresp,
    // Port pins: 0 read strobe, 1 write strobe, 2 chip select
    input  wire pe_pins_t              pinIn,
    output      pe_pins_t              pinOut,
    output      pe_pins_t              pinOe,
    // Slave-port data bus
    input  wire pe_byte_t              pspDataIn,
    output      pe_byte_t              pspDataOut,
    output      logic                  pspDataOe
);
    pe_reg_if rb ();

    pe_axil_slave u_bus (
        .clk           (clk),
        .srst          (srst),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .rb            (rb)
    );

    pe_pins_t  dir_ff;
    pe_pins_t  latch_ff;
    pe_pins_t  ansel_ff;
    logic      parallel_slave_select_ff;
    logic      inFull_ff;
    logic      outFull_ff;
    logic      inOvf_ff;
    logic      wrAct_ff;
    logic      rdAct_ff;
    pe_byte_t  inWord_ff;
    pe_byte_t  outWord_ff;
    pe_pins_t  nxt_dir;
    logic      nxt_parallel_slave_select;
    logic      nxt_inFull;
    logic      nxt_outFull;
    logic      nxt_inOvf;

    // Write decode; only the low byte lane carries data
    wire wrOk      = rb.wrEn && rb.wrStrb;
    wire wrData    = wrOk && rb.wrIdx == `PE_IDX_DATA;
    wire wrDir     = wrOk && rb.wrIdx == `PE_IDX_DIR;
    wire wrAnsel   = wrOk && rb.wrIdx == `PE_IDX_ANSEL;
    wire wrPspBuf  = wrOk && rb.wrIdx == `PE_IDX_PSPBUF;
    wire rdPspBuf  = rb.rdEn && rb.rdIdx == `PE_IDX_PSPBUF;
    wire wrHit     = rb.wrIdx == `PE_IDX_DATA || rb.wrIdx == `PE_IDX_DIR ||
                     rb.wrIdx == `PE_IDX_ANSEL || rb.wrIdx == `PE_IDX_PSPBUF;
    wire rdHit     = rb.rdIdx == `PE_IDX_DATA || rb.rdIdx == `PE_IDX_DIR ||
                     rb.rdIdx == `PE_IDX_ANSEL || rb.rdIdx == `PE_IDX_PSPBUF;

    // Strobes are active low; pins are assumed digital inputs here
    wire extWr     = parallel_slave_select_ff && !pinIn[2] && !pinIn[1];
    wire extRd     = parallel_slave_select_ff && !pinIn[2] && !pinIn[0];
    wire extWrEnd  = wrAct_ff && !extWr;
    wire extRdEnd  = rdAct_ff && !extRd;

    // Analog pins read zero whatever their level
    wire pe_pins_t digIn   = pinIn & ~ansel_ff;
    wire pe_byte_t dirRead = {inFull_ff, outFull_ff, inOvf_ff, parallel_slave_select_ff,
                              1'b0, dir_ff};

    assign rb.wrErr = !wrHit;
    assign rb.rdErr = !rdHit;
    assign rb.rdData = (rb.rdIdx == `PE_IDX_DATA)   ? {5'h00, digIn} :
                       (rb.rdIdx == `PE_IDX_DIR)    ? dirRead :
                       (rb.rdIdx == `PE_IDX_ANSEL)  ? {5'h00, ansel_ff} :
                       (rb.rdIdx == `PE_IDX_PSPBUF) ? inWord_ff : `PE_WORD_RST;

    // Direction stays in force in every mode but slave mode, analog included
    assign pinOut     = latch_ff;
    assign pinOe      = ~dir_ff & {3{~parallel_slave_select_ff}};
    assign pspDataOut = outWord_ff;
    assign pspDataOe  = extRd;

    // Hardware sets win over software clears in the same cycle
    assign nxt_dir     = wrDir ? rb.wrData[2:0] : dir_ff;
    assign nxt_parallel_slave_select = wrDir ? rb.wrData[`PE_BIT_SLAVE_SEL] : parallel_slave_select_ff;
    assign nxt_inFull  = extWrEnd ? 1'b1 : (rdPspBuf ? 1'b0 : inFull_ff);
    assign nxt_outFull = wrPspBuf ? 1'b1 : (extRdEnd ? 1'b0 : outFull_ff);
    assign nxt_inOvf   = (extWrEnd && inFull_ff) ? 1'b1 :
                         (wrDir ? rb.wrData[`PE_BIT_IN_OVF] : inOvf_ff);

    always_ff @(posedge clk) begin
        if (srst) begin
            dir_ff     <= `PE_DIR_RST;
            ansel_ff   <= `PE_ANSEL_RST;
            latch_ff   <= `PE_LATCH_RST;
            parallel_slave_select_ff <= 1'b0;
            inFull_ff  <= 1'b0;
            outFull_ff <= 1'b0;
            inOvf_ff   <= 1'b0;
            wrAct_ff   <= 1'b0;
            rdAct_ff   <= 1'b0;
        end else begin
            dir_ff     <= nxt_dir;
            parallel_slave_select_ff <= nxt_parallel_slave_select;
            inFull_ff  <= nxt_inFull;
            outFull_ff <= nxt_outFull;
            inOvf_ff   <= nxt_inOvf;
            wrAct_ff   <= extWr;
            rdAct_ff   <= extRd;
            if (wrAnsel) ansel_ff <= rb.wrData[2:0];
            if (wrData) latch_ff <= rb.wrData[2:0];
        end
    end

    // Input word follows the bus while the write strobe is low
    always_ff @(posedge clk) begin
        if (srst) begin
            inWord_ff  <= `PE_WORD_RST;
            outWord_ff <= `PE_WORD_RST;
        end else begin
            if (extWr) inWord_ff <= pspDataIn;
            if (wrPspBuf) outWord_ff <= rb.wrData;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_reset_vals;
        disable iff (1'b0)
        srst |=> (ansel_ff == `PE_ANSEL_RST && dir_ff == `PE_DIR_RST && !parallel_slave_select_ff &&
                  !inFull_ff && !outFull_ff && !inOvf_ff);
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    property p_in_full_set;
        extWrEnd |=> inFull_ff;
    endproperty
    a_in_full_set: assert property (p_in_full_set)
        else $error("input full not set after external write");

    property p_in_ovf_set;
        (extWrEnd && inFull_ff) |=> inOvf_ff;
    endproperty
    a_in_ovf_set: assert property (p_in_ovf_set)
        else $error("overflow not flagged");

    property p_in_ovf_sticky;
        (inOvf_ff && !wrDir) |=> inOvf_ff;
    endproperty
    a_in_ovf_sticky: assert property (p_in_ovf_sticky)
        else $error("overflow cleared by hardware");

    property p_out_full_clr;
        (outFull_ff && extRdEnd && !wrPspBuf) |=> !outFull_ff;
    endproperty
    a_out_full_clr: assert property (p_out_full_clr)
        else $error("output full not cleared after read");

    property p_out_full_set;
        wrPspBuf |=> outFull_ff;
    endproperty
    a_out_full_set: assert property (p_out_full_set)
        else $error("output full not set after buffer write");

    property p_dir_oe;
        (wrDir && !rb.wrData[`PE_BIT_SLAVE_SEL]) |=> (pinOe == ~$past(rb.wrData[2:0]));
    endproperty
    a_dir_oe: assert property (p_dir_oe)
        else $error("pin enable does not follow direction");

    property p_analog_zero;
        (rb.rdEn && rb.rdIdx == `PE_IDX_DATA) |-> ((rb.rdData[2:0] & ansel_ff) == 3'h0);
    endproperty
    a_analog_zero: assert property (p_analog_zero)
        else $error("analog pin read nonzero");

    property p_bit3_zero;
        (rb.rdEn && rb.rdIdx == `PE_IDX_DIR) |-> (rb.rdData[3] == 1'b0);
    endproperty
    a_bit3_zero: assert property (p_bit3_zero)
        else $error("unimplemented bit reads one");

    property p_gpio_no_in_full;
        (!parallel_slave_select_ff && !wrAct_ff && !inFull_ff) |=> !inFull_ff;
    endproperty
    a_gpio_no_in_full: assert property (p_gpio_no_in_full)
        else $error("input full set outside slave mode");
endmodule

// ---- testbench/pe_ext_host.sv ----
`timescale 1ns/100ps

module pe_ext_host
    import pe_pkg::*;
(
    // Clock
    input  wire logic     clk,
    // Port pins
    input  wire pe_pins_t pinOut,
    input  wire pe_pins_t pinOe,
    output      pe_pins_t pinIn,
    // Data bus
    input  wire pe_byte_t pspDataOut,
    input  wire logic     pspDataOe,
    output      pe_byte_t pspDataIn
);
    // Strobes idle high: 0 read, 1 write, 2 chip select
    pe_pins_t drv    = 3'h7;
    pe_byte_t busDrv = 8'h00;
    logic     busOn  = 1'b0;

    // Wire level follows whoever enables the pin
    assign pinIn = (pinOe & pinOut) | (~pinOe & drv);
    // Released bus shows the inverse, never a stale copy
    assign pspDataIn = busOn ? busDrv : ~busDrv;

    task automatic ext_write(input pe_byte_t d);
        @(posedge clk);
        drv    <= 3'h1;
        busDrv <= d;
        busOn  <= 1'b1;
        repeat (2) @(posedge clk);
        drv   <= 3'h7;
        busOn <= 1'b0;
        // Strobes stay high between accesses
        repeat (2) @(posedge clk);
    endtask

    task automatic ext_read(output pe_byte_t d);
        @(posedge clk);
        drv <= 3'h2;
        repeat (2) @(posedge clk);
        d = pspDataOe ? pspDataOut : ~pspDataOut;
        drv <= 3'h7;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`include "pe_defs.svh"

module testbench;
    import pe_pkg::*;
    localparam logic [11:0] aData = {`PE_IDX_DATA, 2'b00};
    localparam logic [11:0] aDir  = {`PE_IDX_DIR, 2'b00};
    localparam logic [11:0] aAns  = {`PE_IDX_ANSEL, 2'b00};
    localparam logic [11:0] aBuf  = {`PE_IDX_PSPBUF, 2'b00};
    localparam logic [11:0] aBad  = 12'hFF0;

    logic        clk = 1'b0, srst = 1'b1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    pe_pins_t    pinIn, pinOut, pinOe;
    pe_byte_t    pspDataIn, pspDataOut, b;
    logic        pspDataOe;
    int          nErrors = 0, numChecks = 0;

    pe_port DUT (.clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .pinIn, .pinOut, .pinOe, .pspDataIn, .pspDataOut,
        .pspDataOe);

    pe_ext_host ext (.clk, .pinOut, .pinOe, .pinIn, .pspDataOut, .pspDataOe, .pspDataIn);

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Leading edge keeps a ready just dropped from being raised again in one step
    task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic axiRd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
    endtask

    task automatic completeRun;
        $display("Checks made %0d, errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        nErrors++;
        completeRun;
    end

    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        axiRd(aDir, 32'h07, `PE_RESP_OKAY);
        axiRd(aAns, 32'h07, `PE_RESP_OKAY);
        axiRd(aData, 32'h00, `PE_RESP_OKAY);
        chk(32'(pinOe), 32'h0);
        axiRd(aBad, 32'h00, `PE_RESP_SLVERR);
        axiWr(aBad, 32'hFF, 4'hF, `PE_RESP_SLVERR);
        // Flags in bits 7 and 6 and bit 3 ignore the write; bit 5 takes it
        axiWr(aDir, 32'hE8, 4'hF, `PE_RESP_OKAY);
        axiRd(aDir, 32'h20, `PE_RESP_OKAY);
        chk(32'(pinOe), 32'h7);
        axiWr(aData, 32'h05, 4'hF, `PE_RESP_OKAY);
        chk(32'(pinOut), 32'h5);
        axiRd(aData, 32'h00, `PE_RESP_OKAY);
        axiWr(aAns, 32'h01, 4'hF, `PE_RESP_OKAY);
        axiWr(aDir, 32'h22, 4'hF, `PE_RESP_OKAY);
        chk(32'(pinOe), 32'h5);
        axiRd(aData, 32'h06, `PE_RESP_OKAY);
        axiWr(aDir, 32'h00, 4'hE, `PE_RESP_OKAY);
        axiRd(aDir, 32'h22, `PE_RESP_OKAY);
        axiWr(aDir, 32'h07, 4'hF, `PE_RESP_OKAY);
        axiRd(aDir, 32'h07, `PE_RESP_OKAY);
        ext.ext_write(8'h11);
        axiRd(aDir, 32'h07, `PE_RESP_OKAY);
        // Pins digital inputs before slave mode
        axiWr(aAns, 32'h00, 4'hF, `PE_RESP_OKAY);
        axiWr(aDir, 32'h17, 4'hF, `PE_RESP_OKAY);
        chk(32'(pinOe), 32'h0);
        ext.ext_write(8'hA5);
        axiRd(aDir, 32'h97, `PE_RESP_OKAY);
        axiRd(aBuf, 32'hA5, `PE_RESP_OKAY);
        axiRd(aDir, 32'h17, `PE_RESP_OKAY);
        ext.ext_write(8'h3C);
        ext.ext_write(8'hC3);
        axiRd(aDir, 32'hB7, `PE_RESP_OKAY);
        axiWr(aDir, 32'h17, 4'hF, `PE_RESP_OKAY);
        axiRd(aDir, 32'h97, `PE_RESP_OKAY);
        axiWr(aBuf, 32'h5A, 4'hF, `PE_RESP_OKAY);
        axiRd(aDir, 32'hD7, `PE_RESP_OKAY);
        ext.ext_read(b);
        chk(32'(b), 32'h5A);
        axiRd(aDir, 32'h97, `PE_RESP_OKAY);
        // Mid-run reset must drop flags, mode and latch and set all pins analog again
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        chk(32'(pinOut), 32'h0);
        axiRd(aDir, 32'h07, `PE_RESP_OKAY);
        axiRd(aAns, 32'h07, `PE_RESP_OKAY);
        completeRun;
    end
endmodule
